// file: logic/timer_consts.svh
// Register offsets, field positions, reset values and limits of the timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Byte offsets on the register bus
`define OFS_CLK_SEL 4'h0
`define OFS_MODE 4'h4
`define OFS_COMPARE 4'h8
`define OFS_COUNTER 4'hc

// Mode control field positions
`define BIT_COUNT_EN 7
`define BIT_PWM_SEL 6
`define BIT_LEVEL_SET 3
`define BIT_LEVEL_RST 2
`define BIT_INV_ACT 1
`define BIT_OUT_EN 0

// Bits of the mode control register that are stored
`define MODE_STORE_MASK 8'hc3

// Reset values
`define RST_CLK_SEL 3'h0
`define RST_MODE 8'h00
`define RST_COMPARE 8'h00
`define RST_COUNTER 8'h00

// Counter limits and count clock codes
`define COUNT_MAX 8'hff
`define SEL_EXT_FALL 3'h0
`define SEL_EXT_RISE 3'h1
`define PRESCALE_W 11

`endif

// file: logic/timer_pkg.sv
// Types shared by the timer channel
package timer_pkg;

   // Phases of the free-running pulse-width output
   typedef enum logic [2:0] {
      PWM_WAIT = 3'b001,
      PWM_ACTIVE = 3'b010,
      PWM_INACTIVE = 3'b100
   } pwm_phase_t;

endpackage : timer_pkg

// file: logic/edge_sync.sv
// Three-stage synchroniser and edge detector for the external event pin
module edge_sync (
   // Clock, enable and reset
   input wire logic core_clk,
   input wire logic clk_en,
   input wire logic arst_n,
   // Pin and detected edges
   input wire logic pin_in,
   output logic rise,
   output logic fall
);

   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic level_reg;
   logic rise_reg;
   logic fall_reg;

   // A change counts only once the second and third stage agree
   wire agree = sync2_reg == sync3_reg;
   wire level_next = agree ? sync3_reg : level_reg;
   wire rise_next = agree && sync3_reg && !level_reg;
   wire fall_next = agree && !sync3_reg && level_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         level_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else if (clk_en) begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         level_reg <= level_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   assign rise = rise_reg;
   assign fall = fall_reg;

endmodule // edge_sync

// file: logic/count_prescaler.sv
// Prescaler that divides the system clock for the count clock
`include "timer_consts.svh"

module count_prescaler (
   // Clock, enable and reset
   input wire logic core_clk,
   input wire logic clk_en,
   input wire logic arst_n,
   // Control
   input wire logic run,
   input wire logic [2:0] sel,
   // One-cycle count pulse
   output logic tick
);

   logic [`PRESCALE_W-1:0] prescale_reg;

   // Divide by 2, 8, 32, 128, 512 or 2048 for codes 2 to 7
   function automatic logic [`PRESCALE_W-1:0] div_mask(input logic [2:0] s);
      case (s)
         3'h2: div_mask = 11'h001;
         3'h3: div_mask = 11'h007;
         3'h4: div_mask = 11'h01f;
         3'h5: div_mask = 11'h07f;
         3'h6: div_mask = 11'h1ff;
         3'h7: div_mask = 11'h7ff;
         default: div_mask = 11'h000;
      endcase
   endfunction

   wire [`PRESCALE_W-1:0] mask = div_mask(sel);
   wire internal_src = sel[2:1] != 2'h0;
   wire [`PRESCALE_W-1:0] prescale_next = run ?
      `PRESCALE_W'(prescale_reg + 11'h001) : 11'h000;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prescale_reg <= 11'h000;
      end else if (clk_en) begin
         prescale_reg <= prescale_next;
      end
   end

   assign tick = run && internal_src && ((prescale_reg & mask) == mask);

endmodule // count_prescaler

// file: logic/event_timer.sv
// One 8-bit timer/event counter channel with an Avalon-MM register slave
// Operation
// R1 - Clear-and-start: match clears counter, raises interrupt
// R2 - Match interval is compare plus one ticks
// R3 - Three-bit field selects the count clock
// R4 - Count enable one starts, zero stops
// R5 - Event mode counts selected pin edge
// R6 - Event mode match clears counter, raises interrupt
// R7 - Inversion enabled: output toggles on match
// R8 - Set/reset bits choose initial output level
// R9 - Pin driven only while output enabled
// R10 - Mode bit selects PWM or clear-and-start
// R11 - PWM: compare is width, bit one polarity
// R12 - PWM: inactive until first overflow
// R13 - PWM: overflow drives active until match
// R14 - PWM: match returns inactive until overflow
// R15 - PWM: stop forces inactive output at once
// R16 - Software rewrites compare once per cycle
// R17 - First match may slip one count clock
// R18 - Compare below counter waits for overflow
// R19 - Software restarts after lowering compare
// R20 - Counter read holds count clock briefly
// R21 - Software stops count before stop state
// R22 - Disable clears counter and stops prescaler
// R23 - Set/reset pair: keep, clear, set, ignore
// R24 - Set/reset bits always read zero
// R25 - PWM wraps FFH to 00H as overflow
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`include "timer_consts.svh"

module event_timer (
   // Clock, enable and reset
   input wire logic core_clk,
   input wire logic clk_en,
   input wire logic arst_n,
   // Avalon-MM register slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Event input pin
   input wire logic external_event_input,
   // Timer output pin
   output logic timer_output_pin_o,
   output logic timer_output_pin_oe,
   // Match interrupt
   output logic match_interrupt_request
);

   logic [2:0] count_clock_select_reg;
   logic [7:0] timer_mode_control_reg;
   logic [7:0] compare_value_reg;
   logic [7:0] counter_value_reg;
   logic output_ff_reg;
   timer_pkg::pwm_phase_t phase_reg;
   timer_pkg::pwm_phase_t phase_next;
   logic irq_reg;
   logic pin_out_reg;
   logic pin_oe_reg;
   logic held_reg;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic presc_tick;
   logic ev_rise;
   logic ev_fall;

   // Bus decode: one wait cycle, then the access completes
   wire bus_req = read || write;
   wire access_edge = !waitrequest_reg;
   wire wr_sel = write && access_edge && address == `OFS_CLK_SEL;
   wire wr_mode = write && access_edge && address == `OFS_MODE;
   wire wr_cmp = write && access_edge && address == `OFS_COMPARE;
   wire waitrequest_next = !(bus_req && waitrequest_reg);

   // Register next values
   wire [2:0] sel_next = wr_sel ? writedata[2:0] :
      count_clock_select_reg; // [R3]
   wire [7:0] mode_next = wr_mode ?
      (writedata[7:0] & `MODE_STORE_MASK) : timer_mode_control_reg; // [R24]
   wire [7:0] cmp_next = wr_cmp ? writedata[7:0] : compare_value_reg;

   // Mode fields
   wire count_enable_bit = timer_mode_control_reg[`BIT_COUNT_EN];
   wire pwm_mode_select_bit = timer_mode_control_reg[`BIT_PWM_SEL];
   wire invert_or_active_level_bit = timer_mode_control_reg[`BIT_INV_ACT];
   wire output_enable_bit = mode_next[`BIT_OUT_EN];
   wire enable_next = mode_next[`BIT_COUNT_EN];
   wire pwm_next = mode_next[`BIT_PWM_SEL];
   wire level_set = wr_mode && writedata[`BIT_LEVEL_SET];
   wire level_rst = wr_mode && writedata[`BIT_LEVEL_RST];

   edge_sync event_sync (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .arst_n(arst_n),
      .pin_in(external_event_input),
      .rise(ev_rise),
      .fall(ev_fall)
   );

   count_prescaler prescaler (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .arst_n(arst_n),
      .run(count_enable_bit), // [R22]
      .sel(count_clock_select_reg), // [R3]
      .tick(presc_tick)
   );

   // Count source; the prescaler is held at zero until the start write, so the
   // first match comes compare plus one whole count clocks after the start
   wire ext_mode = count_clock_select_reg[2:1] == 2'h0;
   wire ext_edge = (count_clock_select_reg == `SEL_EXT_RISE) ?
      ev_rise : ev_fall; // [R5]
   wire raw_tick = count_enable_bit &&
      (ext_mode ? ext_edge : presc_tick); // [R4] [R17]

   // A counter read holds off one count pulse so the snapshot stays
   // coherent; the pulse is applied a cycle later, never lost
   wire cnt_read_hold = read && waitrequest_reg &&
      address == `OFS_COUNTER; // [R20]
   wire held_next = count_enable_bit && raw_tick && cnt_read_hold;
   wire tick = count_enable_bit &&
      ((raw_tick && !cnt_read_hold) || held_reg);

   // Match and overflow events
   wire at_match = counter_value_reg == compare_value_reg;
   wire at_max = counter_value_reg == `COUNT_MAX;
   wire clr_hit = tick && !pwm_mode_select_bit && at_match; // [R1] [R6]
   wire pwm_ovf = tick && pwm_mode_select_bit && at_max; // [R25]
   wire pwm_hit = tick && pwm_mode_select_bit && at_match;
   wire irq_next = clr_hit || pwm_hit;

   // Counter: a compare below the count runs on through FFH to 00H
   wire [7:0] counter_inc = 8'(counter_value_reg + 8'h01); // [R18] [R25]
   wire [7:0] counter_next = !enable_next ? `RST_COUNTER :
      clr_hit ? `RST_COUNTER :
      tick ? counter_inc : counter_value_reg; // [R22] [R1] [R2]

   // Output flip-flop: a software set or reset wins over a toggle;
   // both bits together hold it, blocking a toggle on the same match
   wire ff_next = (level_set && !level_rst) ? 1'b1 :
      (level_rst && !level_set) ? 1'b0 :
      (level_set && level_rst) ? output_ff_reg :
      (clr_hit && invert_or_active_level_bit) ? !output_ff_reg :
      output_ff_reg; // [R8] [R23] [R7]

   // Pulse-width phase sequencing
   always_comb begin
      phase_next = phase_reg;
      if (!enable_next || !pwm_next) begin
         phase_next = timer_pkg::PWM_WAIT; // [R15]
      end else begin
         case (phase_reg)
            timer_pkg::PWM_WAIT: begin
               if (pwm_ovf) begin
                  phase_next = timer_pkg::PWM_ACTIVE; // [R12]
               end
            end
            timer_pkg::PWM_ACTIVE: begin
               if (pwm_hit && !pwm_ovf) begin
                  phase_next = timer_pkg::PWM_INACTIVE; // [R14]
               end
            end
            timer_pkg::PWM_INACTIVE: begin
               if (pwm_ovf) begin
                  phase_next = timer_pkg::PWM_ACTIVE; // [R13]
               end
            end
            default: begin
               phase_next = timer_pkg::PWM_WAIT;
            end
         endcase
      end
   end

   // Output level; polarity follows the new mode so a stop is immediate
   wire active_low = mode_next[`BIT_INV_ACT]; // [R11]
   wire pwm_level = (phase_next == timer_pkg::PWM_ACTIVE) ^ active_low;
   wire pin_out_next = pwm_next ? pwm_level : ff_next; // [R10]
   wire pin_oe_next = output_enable_bit; // [R9]

   // Read data, zero for unmapped offsets
   wire [31:0] rd_sel = {29'h0, count_clock_select_reg};
   wire [31:0] rd_mode = {24'h0, timer_mode_control_reg}; // [R24]
   wire [31:0] rd_cmp = {24'h0, compare_value_reg};
   wire [31:0] rd_cnt = {24'h0, counter_value_reg};
   wire [31:0] rd_mux = (address == `OFS_CLK_SEL) ? rd_sel :
      (address == `OFS_MODE) ? rd_mode :
      (address == `OFS_COMPARE) ? rd_cmp :
      (address == `OFS_COUNTER) ? rd_cnt : 32'h0;
   wire [31:0] readdata_next = (read && waitrequest_reg) ? rd_mux :
      readdata_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_clock_select_reg <= `RST_CLK_SEL;
         timer_mode_control_reg <= `RST_MODE;
         compare_value_reg <= `RST_COMPARE;
         counter_value_reg <= `RST_COUNTER;
         held_reg <= 1'b0;
      end else if (clk_en) begin
         count_clock_select_reg <= sel_next;
         timer_mode_control_reg <= mode_next;
         compare_value_reg <= cmp_next;
         counter_value_reg <= counter_next;
         held_reg <= held_next;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         output_ff_reg <= 1'b0;
         phase_reg <= timer_pkg::PWM_WAIT;
         irq_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else if (clk_en) begin
         output_ff_reg <= ff_next;
         phase_reg <= phase_next;
         irq_reg <= irq_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest_reg <= 1'b1;
         readdata_reg <= 32'h0;
      end else if (clk_en) begin
         waitrequest_reg <= waitrequest_next;
         readdata_reg <= readdata_next;
      end
   end

   assign readdata = readdata_reg;
   assign waitrequest = waitrequest_reg;
   assign timer_output_pin_o = pin_out_reg;
   assign timer_output_pin_oe = pin_oe_reg;
   assign match_interrupt_request = irq_reg;

   // Checks
   default clocking chk_clk @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   match_clears_count_a: assert property ( // [R1]
      clk_en && clr_hit |=> counter_value_reg == 8'h00 && irq_reg)
      else $error("clear-mode match did not clear counter and interrupt");

   interrupt_cause_a: assert property ( // [R6]
      irq_reg && $past(clk_en) |->
      $past(tick) && $past(at_match))
      else $error("interrupt without a match on a count pulse");

   count_step_a: assert property ( // [R2]
      clk_en && tick && !clr_hit && enable_next |=>
      counter_value_reg == 8'($past(counter_value_reg) + 8'h01))
      else $error("counter did not advance by one on a count pulse");

   disable_clear_a: assert property ( // [R22]
      !count_enable_bit |-> counter_value_reg == 8'h00 &&
      phase_reg == timer_pkg::PWM_WAIT)
      else $error("disabled timer holds a nonzero count");

   toggle_on_match_a: assert property ( // [R7]
      clk_en && clr_hit && invert_or_active_level_bit && !wr_mode |=>
      output_ff_reg != $past(output_ff_reg))
      else $error("output flip-flop did not toggle on match");

   level_write_a: assert property ( // [R23]
      clk_en && wr_mode && writedata[3:2] == 2'h2 |=> output_ff_reg)
      else $error("level set write did not set the flip-flop");

   pwm_stop_idle_a: assert property ( // [R15]
      clk_en && count_enable_bit && !enable_next && pwm_next |=>
      pin_out_reg == timer_mode_control_reg[`BIT_INV_ACT])
      else $error("stopped pulse output not at inactive level");

   pwm_first_wait_a: assert property ( // [R12]
      phase_reg == timer_pkg::PWM_WAIT && pwm_mode_select_bit &&
      clk_en && !pwm_ovf && !wr_mode |=>
      pin_out_reg == invert_or_active_level_bit)
      else $error("pulse output active before first overflow");

   oe_follow_a: assert property ( // [R9]
      clk_en |=> timer_output_pin_oe ==
      timer_mode_control_reg[`BIT_OUT_EN])
      else $error("output enable does not follow its bit");

   level_read_zero_a: assert property ( // [R24]
      !waitrequest_reg && read |-> readdata_reg[5:2] == 4'h0 ||
      address != `OFS_MODE)
      else $error("level bits read back nonzero");

   bus_answer_a: assert property (
      clk_en && bus_req && waitrequest_reg |=> !waitrequest_reg)
      else $error("bus request not answered after one wait cycle");

   sel_write_a: assert property ( // [R3]
      clk_en && wr_sel |=>
      count_clock_select_reg == $past(writedata[2:0]))
      else $error("clock select write did not land");

   start_write_a: assert property ( // [R4]
      clk_en && wr_mode |=>
      count_enable_bit == $past(writedata[`BIT_COUNT_EN]))
      else $error("count enable write did not land");

   count_hold_a: assert property ( // [R5]
      clk_en && !tick && enable_next |=>
      counter_value_reg == $past(counter_value_reg))
      else $error("counter moved without a count pulse");

   level_clear_a: assert property ( // [R23]
      clk_en && wr_mode && writedata[3:2] == 2'h1 |=> !output_ff_reg)
      else $error("level reset write did not clear the flip-flop");

   pwm_wrap_active_a: assert property ( // [R13]
      clk_en && pwm_ovf && enable_next && pwm_next |=>
      timer_output_pin_o == !timer_mode_control_reg[`BIT_INV_ACT])
      else $error("pulse output not active after overflow");

   pwm_match_idle_a: assert property ( // [R14]
      clk_en && pwm_hit && !pwm_ovf && enable_next && pwm_next |=>
      timer_output_pin_o == timer_mode_control_reg[`BIT_INV_ACT])
      else $error("pulse output not inactive after match");

   pwm_no_clear_a: assert property ( // [R25]
      clk_en && pwm_hit && !at_max && enable_next && pwm_next |=>
      counter_value_reg != 8'h00)
      else $error("pulse mode match cleared the counter");

   count_stop_c: cover property (count_enable_bit && !enable_next);
   clear_mode_match_c: cover property (clk_en && clr_hit);
   pwm_full_cycle_c: cover property (
      phase_reg == timer_pkg::PWM_ACTIVE ##[1:600]
      phase_reg == timer_pkg::PWM_INACTIVE);
   event_count_c: cover property (ext_mode && tick);
   held_tick_c: cover property (held_reg);

endmodule // event_timer

// file: test/event_source.sv
// Partner model: source of pulses on the external event pin
module event_source (
   // Clock
   input wire logic core_clk,
   // Event pin
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;

   initial pin = 1'b0;

   // Each level held four cycles, well above the two-cycle minimum
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge core_clk);
         pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         pin <= 1'b0;
      end
      // Let the synchroniser drain before anyone reads the counter
      repeat (8) @(posedge core_clk);
   endtask
endmodule // event_source

// file: test/event_timer_tb_top.sv
// Self-checking testbench of one timer channel
`include "timer_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   miscompares++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end

module event_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic ev_pin;
   logic [31:0] readdata;
   logic waitrequest;
   logic pin_o;
   logic pin_oe;
   logic irq;
   int miscompares = 0;
   int cmp_count = 0;
   int irq_count = 0;

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (irq === 1'b1) irq_count++;

   event_timer i_event_timer (
      .core_clk(core_clk), .clk_en(clk_en), .arst_n(arst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .external_event_input(ev_pin),
      .timer_output_pin_o(pin_o), .timer_output_pin_oe(pin_oe),
      .match_interrupt_request(irq)
   );

   event_source i_event_source (.core_clk(core_clk), .pin(ev_pin));

   // Request held until waitrequest is sampled low; no fixed latency
   task automatic bus(input logic rd, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      @(posedge core_clk);
      address <= a;
      writedata <= {24'h0, d};
      read <= rd;
      write <= !rd;
      do begin
         @(posedge core_clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Outputs launched at the completing edge settle before any check
      @(negedge core_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask

   // Cycles until irq (sel 0) or pin_o (sel 1) is sampled at v
   task automatic wait_for(input logic v, input bit sel, input int lim,
                           output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while ((sel ? pin_o : irq) !== v && c < lim);
      `CHK("wait level", v, sel ? pin_o : irq)
   endtask

   task automatic t_regs();
      logic [31:0] q;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 4'(i * 4), 8'h00, q);
         `CHK("reset value", 32'h0, q)
      end
      wr(4'h2, 8'hff);
      bus(1'b1, 4'h2, 8'h00, q);
      `CHK("unmapped", 32'h0, q)
      wr(`OFS_MODE, 8'h09);
      bus(1'b1, `OFS_MODE, 8'h00, q);
      `CHK("level bits read", 32'h01, q)
      `CHK("pin set", 1'b1, pin_o)
      `CHK("oe on", 1'b1, pin_oe)
      wr(`OFS_MODE, 8'h0c);
      `CHK("both ignored", 1'b1, pin_o)
      `CHK("oe off", 1'b0, pin_oe)
      wr(`OFS_MODE, 8'h05);
      `CHK("pin reset", 1'b0, pin_o)
      wr(`OFS_COMPARE, 8'hab);
      bus(1'b1, `OFS_COMPARE, 8'h00, q);
      `CHK("compare", 32'hab, q)
   endtask

   task automatic t_interval();
      int div[3] = '{2, 8, 32};
      int c0;
      int c1;
      int c2;
      int n;
      logic [31:0] q;
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_CLK_SEL, 8'(i + 2));
         wr(`OFS_COMPARE, 8'h03);
         wr(`OFS_MODE, 8'h80);
         wait_for(1'b1, 0, 400, c0);
         wait_for(1'b0, 0, 4, c1);
         wait_for(1'b1, 0, 400, c2);
         `CHK("interval", 4 * div[i], c1 + c2)
         wr(`OFS_MODE, 8'h00);
         bus(1'b1, `OFS_COUNTER, 8'h00, q);
         `CHK("counter cleared", 32'h0, q)
      end
      n = irq_count;
      repeat (100) @(posedge core_clk);
      `CHK("stopped", n, irq_count)
   endtask

   task automatic t_square();
      int c;
      logic p0;
      wr(`OFS_CLK_SEL, 8'h02);
      wr(`OFS_MODE, 8'h0b);
      `CHK("initial high", 1'b1, pin_o)
      wr(`OFS_MODE, 8'h83);
      wait_for(1'b1, 0, 100, c);
      p0 = pin_o;
      `CHK("first toggle", 1'b0, p0)
      wait_for(1'b0, 0, 4, c);
      wait_for(1'b1, 0, 100, c);
      `CHK("second toggle", ~p0, pin_o)
      wr(`OFS_MODE, 8'h00);
   endtask

   task automatic t_event();
      int n;
      logic [31:0] q;
      // Both edge codes: 0 falling, 1 rising
      for (int s = 0; s < 2; s++) begin
         wr(`OFS_CLK_SEL, 8'(s));
         wr(`OFS_COMPARE, 8'h02);
         wr(`OFS_MODE, 8'h80);
         n = irq_count;
         i_event_source.pulses(3);
         `CHK("event match", n + 1, irq_count)
         bus(1'b1, `OFS_COUNTER, 8'h00, q);
         `CHK("event clear", 32'h0, q)
         i_event_source.pulses(2);
         bus(1'b1, `OFS_COUNTER, 8'h00, q);
         `CHK("event count", 32'h2, q)
         wr(`OFS_MODE, 8'h00);
      end
   endtask

   task automatic t_pwm();
      int c;
      int n;
      logic [31:0] q;
      wr(`OFS_CLK_SEL, 8'h02);
      wr(`OFS_COMPARE, 8'h03);
      wr(`OFS_MODE, 8'hc1);
      n = irq_count;
      wait_for(1'b1, 1, 600, c);
      `CHK("wait overflow", 1'b1, 1'(c > 480 && c < 530))
      wait_for(1'b0, 1, 20, c);
      `CHK("active width", 8, c)
      wait_for(1'b1, 1, 600, c);
      `CHK("inactive width", 504, c)
      `CHK("pwm matches", n + 2, irq_count)
      wr(`OFS_MODE, 8'h00);
      wr(`OFS_MODE, 8'hc3);
      `CHK("low inactive", 1'b1, pin_o)
      wait_for(1'b0, 1, 600, c);
      wr(`OFS_MODE, 8'h43);
      repeat (2) @(posedge core_clk);
      `CHK("stop inactive", 1'b1, pin_o)
      bus(1'b1, `OFS_COUNTER, 8'h00, q);
      `CHK("pwm counter", 32'h0, q)
      wr(`OFS_MODE, 8'h00);
   endtask

   task automatic t_lower();
      int n;
      int c;
      wr(`OFS_CLK_SEL, 8'h02);
      wr(`OFS_COMPARE, 8'h80);
      wr(`OFS_MODE, 8'h80);
      repeat (60) @(posedge core_clk);
      wr(`OFS_COMPARE, 8'h05);
      n = irq_count;
      repeat (300) @(posedge core_clk);
      `CHK("no early match", n, irq_count)
      wait_for(1'b1, 0, 800, c);
      `CHK("match after wrap", 1'b1, irq)
      // Restarting after lowering the compare avoids the wrap delay
      wr(`OFS_MODE, 8'h00);
      wr(`OFS_MODE, 8'h80);
      wait_for(1'b1, 0, 40, c);
      `CHK("restart", 1'b1, 1'(c >= 10 && c <= 14))
      wr(`OFS_MODE, 8'h00);
   endtask

   task automatic t_freeze();
      int c;
      wr(`OFS_CLK_SEL, 8'h02);
      wr(`OFS_COMPARE, 8'h03);
      wr(`OFS_MODE, 8'h80);
      wait_for(1'b1, 0, 100, c);
      // Ten frozen edges push the next match out by ten cycles
      clk_en <= 1'b0;
      repeat (10) @(posedge core_clk);
      clk_en <= 1'b1;
      wait_for(1'b1, 0, 100, c);
      `CHK("frozen interval", 8, c)
      wr(`OFS_MODE, 8'h00);
   endtask

   task automatic t_reset();
      logic [31:0] q;
      wr(`OFS_MODE, 8'h89);
      @(posedge core_clk);
      arst_n <= 1'b0;
      @(posedge core_clk);
      `CHK("mid reset pin", 1'b0, pin_o)
      `CHK("mid reset oe", 1'b0, pin_oe)
      `CHK("mid reset wait", 1'b1, waitrequest)
      arst_n <= 1'b1;
      bus(1'b1, `OFS_MODE, 8'h00, q);
      `CHK("mid reset mode", 32'h0, q)
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      `CHK("reset wait", 1'b1, waitrequest)
      `CHK("reset oe", 1'b0, pin_oe)
      arst_n <= 1'b1;
      t_regs();
      t_interval();
      t_square();
      t_event();
      t_pwm();
      t_lower();
      t_freeze();
      t_reset();
      tally_and_finish();
   end

   // The scenarios need well under 10000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      tally_and_finish();
   end
endmodule // event_timer_tb_top
